// [design/dfch_pkg.sv]
// constants and types of the debug firmware command handler
`default_nettype none
package dfch_pkg;
	// firmware opcodes
	localparam logic [7:0] OP_READ_NEXT               = 8'h62;
	localparam logic [7:0] OP_FETCH_PROGRAM_COUNTER   = 8'h63;
	localparam logic [7:0] OP_FETCH_D                 = 8'h64;
	localparam logic [7:0] OP_FETCH_X                 = 8'h65;
	localparam logic [7:0] OP_FETCH_Y                 = 8'h66;
	localparam logic [7:0] OP_FETCH_STACK_POINTER     = 8'h67;
	localparam logic [7:0] OP_WRITE_NEXT              = 8'h42;
	localparam logic [7:0] OP_LOAD_PROGRAM_COUNTER    = 8'h43;
	localparam logic [7:0] OP_LOAD_STACK_POINTER      = 8'h47;
	localparam logic [7:0] OP_RESUME                  = 8'h08;
	localparam logic [7:0] OP_RESUME_UNTIL            = 8'h0C;
	localparam logic [7:0] OP_SINGLE_STEP             = 8'h10;
	localparam logic [7:0] OP_DEPRECATED_TAG_RESUME   = 8'h18;
	// cpu register selects on reg_sel
	localparam logic [2:0] REG_PC                     = 3'h0;
	localparam logic [2:0] REG_D                      = 3'h1;
	localparam logic [2:0] REG_X                      = 3'h2;
	localparam logic [2:0] REG_Y                      = 3'h3;
	localparam logic [2:0] REG_SP                     = 3'h4;
	localparam logic [2:0] REG_SEL_BASE               = 3'h3;
	// debug space 0x7FFF00..0x7FFFFF, registers in its first 0x0C bytes
	localparam logic [14:0] DBG_SPACE_PAGE            = 15'h7FFF;
	localparam logic [7:0]  DBG_REGS_END              = 8'h0C;
	localparam logic [15:0] NEXT_STEP                 = 16'h0002;
	// serial timing in target clocks
	localparam logic [8:0] SAMPLE_TICK                = 9'h00A;
	localparam logic [8:0] BIT_LAST_TICK              = 9'h00F;
	localparam logic [8:0] TX0_LOW_TICKS              = 9'h00D;
	localparam logic [8:0] TX1_SPEEDUP_TICK           = 9'h007;
	localparam logic [8:0] TIMEOUT_TICKS              = 9'h1FF;
	localparam logic [8:0] ACK_LOW_TICKS              = 9'h010;
	localparam logic [5:0] ACK_MIN_GAP                = 6'h20;
	localparam logic [4:0] OPCODE_BITS                = 5'h08;
	localparam logic [4:0] WORD_BITS                  = 5'h10;

	typedef enum logic [3:0] {
		ST_OPCODE,
		ST_DATA,
		ST_EXEC,
		ST_MEM,
		ST_ACK_WAIT,
		ST_ACK_LOW,
		ST_ACK_HIGH,
		ST_SEND,
		ST_LEAVE,
		ST_RETURN
	} dfch_state_t;

	// whole state of the handler, registered as one word
	typedef struct packed {
		dfch_state_t st;
		dfch_state_t after;
		logic [8:0]  tick;
		logic        inbit;
		logic [4:0]  bits;
		logic [15:0] shreg;
		logic [7:0]  op;
		logic [5:0]  gap;
		logic        prev_pin;
		logic        ack_ok;
		logic        left;
		logic        dbgacc;
		logic        dwait;
		logic        dm_re;
		logic        dm_we;
		logic        pin_out;
		logic        pin_oe;
		logic        reg_wr;
		logic [2:0]  reg_sel;
		logic [15:0] reg_wdata;
		logic        mem_req;
		logic        mem_we;
		logic [22:0] mem_addr;
		logic [15:0] mem_wdata;
		logic        resume;
		logic        step;
		logic        dbg_map;
	} dfch_regs_t;

	// idle line reads high, so the edge detector starts high
	localparam dfch_regs_t RESET_REGS = '{
		st: ST_OPCODE, after: ST_OPCODE, prev_pin: 1'b1, default: '0
	};
endpackage : dfch_pkg
`default_nettype wire

// [design/dfch_dbg_mem.sv]
// debug register and firmware table storage, 128 words with registered read
`default_nettype none
module dfch_dbg_mem (
	input  wire logic        clk,
	input  wire logic        re,
	input  wire logic        we,
	input  wire logic [6:0]  addr,
	input  wire logic [15:0] wdata,
	output var  logic [15:0] rdata
);
	logic [15:0] mem [0:127];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		if (re) begin
			rdata <= mem[addr];
		end
	end
endmodule : dfch_dbg_mem
`default_nettype wire

// [design/dfch_top.sv]
// firmware debug command handler: serial framing, decode, execution and acknowledge
// Operation
// R1: firmware commands run only while active background debug mode holds
// R2: debug space 0x7FFF00-0x7FFFFF becomes visible on entering background debug
// R3: opcode 62 adds two to X, then returns word at new X
// R4: opcodes 63..67 return PC, D, X, Y, SP as 16 bits
// R5: opcode 42 adds two to X, then stores received word at new X
// R6: opcodes 43..47 load received word into PC, D, X, Y, SP
// R7: opcode 08 resumes; acknowledge issued when background mode is left
// R8: opcode 0C resumes; acknowledge issued when background mode is re-entered
// R9: opcode 10 runs one instruction, returns, then acknowledges
// R10: opcode 18 behaves exactly as resume; host should not send it
// R11: reads acknowledged when data ready, writes after write completes
// R12: command is 8-bit opcode then 16-bit address and/or data word
// R13: every read returns 16 bits; byte sits by address parity
// R14: next-access into debug space hits debug resources; firmware not writable
// R15: system stop disables acknowledge; wait/stop before return cancels it
// R16: misaligned 16-bit access drops address bit zero
// R17: without acknowledge host waits 150 bus clocks on hardware accesses
// R18: without acknowledge host waits 48 clocks before fetching read data
// R19: without acknowledge host waits 36 clocks after write data
// R20: host waits 76 clocks after step or resume before next command
// R21: host should use acknowledge when bus rate is unknown
// R22: line idles high; opcode is eight 16-clock bit times
// R23: bits MSB first, 16 clocks each; 512 clocks without edge times out; the code times out only after the first bit of an opcode or word
// R24: acknowledge is 16 low clocks plus speed-up, at least 32 after end
// R25: unrecognised opcodes are ignored without register change or acknowledge
`default_nettype none
module dfch_top (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        debug_serial_pin_in,
	output var  logic        debug_serial_pin_out,
	output var  logic        debug_serial_pin_oe,
	input  wire logic        background_debug_active,
	input  wire logic        ack_enable,
	input  wire logic        sys_stop,
	input  wire logic        cpu_wait_stop,
	input  wire logic [15:0] pc_in,
	input  wire logic [15:0] d_in,
	input  wire logic [15:0] x_in,
	input  wire logic [15:0] y_in,
	input  wire logic [15:0] sp_in,
	input  wire logic [6:0]  global_page,
	output var  logic        reg_wr,
	output var  logic [2:0]  reg_sel,
	output var  logic [15:0] reg_wdata,
	output var  logic        mem_req,
	output var  logic        mem_we,
	output var  logic [22:0] mem_addr,
	output var  logic [15:0] mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [15:0] mem_rdata,
	output var  logic        resume,
	output var  logic        step,
	output var  logic        debug_map_visible
);
	dfch_pkg::dfch_regs_t  s;
	dfch_pkg::dfch_regs_t  next_s;
	logic                  fall;
	logic                  fin;
	dfch_pkg::dfch_state_t fin_to;
	logic [15:0]           nx;
	logic [15:0]           dm_rdata;

	function automatic logic [2:0] dfch_reg_of(input logic [7:0] op);
		return 3'(op[2:0] - dfch_pkg::REG_SEL_BASE);
	endfunction : dfch_reg_of

	function automatic logic dfch_in_dbg(input logic [22:0] addr);
		return addr[22:8] == dfch_pkg::DBG_SPACE_PAGE;
	endfunction : dfch_in_dbg

	assign fall = s.prev_pin & ~debug_serial_pin_in;

	always_comb begin
		next_s = s;
		fin = 1'b0;
		fin_to = dfch_pkg::ST_OPCODE;
		nx = 16'(x_in + dfch_pkg::NEXT_STEP);
		next_s.prev_pin = debug_serial_pin_in;
		next_s.reg_wr = 1'b0;
		next_s.resume = 1'b0;
		next_s.step = 1'b0;
		next_s.pin_oe = 1'b0;
		next_s.pin_out = 1'b0;
		next_s.dbg_map = background_debug_active; // see R2
		if (s.gap != dfch_pkg::ACK_MIN_GAP) begin
			next_s.gap = 6'(s.gap + 6'h01);
		end
		case (s.st)
			dfch_pkg::ST_OPCODE, dfch_pkg::ST_DATA, dfch_pkg::ST_SEND: begin
				// bit engine; each host falling edge opens a 16-clock bit time, see R22 R23
				if (fall) begin
					next_s.tick = '0;
					next_s.inbit = 1'b1;
				end else if (s.tick != dfch_pkg::TIMEOUT_TICKS) begin
					next_s.tick = 9'(s.tick + 9'h001);
				end
				if (s.st != dfch_pkg::ST_SEND && s.inbit && s.tick == dfch_pkg::SAMPLE_TICK) begin
					next_s.shreg = {s.shreg[14:0], debug_serial_pin_in}; // see R23
					next_s.bits = 5'(s.bits + 5'h01);
				end
				if (s.inbit && s.tick == dfch_pkg::BIT_LAST_TICK) begin
					next_s.inbit = 1'b0;
					if (s.st == dfch_pkg::ST_SEND) begin
						next_s.shreg = {s.shreg[14:0], 1'b0};
						next_s.bits = 5'(s.bits + 5'h01);
						if (s.bits + 5'h01 == dfch_pkg::WORD_BITS) begin
							next_s.st = dfch_pkg::ST_OPCODE; // see R13
							next_s.bits = '0;
						end
					end else if (s.st == dfch_pkg::ST_DATA && s.bits == dfch_pkg::WORD_BITS) begin
						next_s.gap = '0; // see R12
						next_s.st = dfch_pkg::ST_EXEC;
					end else if (s.st == dfch_pkg::ST_OPCODE && s.bits == dfch_pkg::OPCODE_BITS) begin
						next_s.op = s.shreg[7:0];
						next_s.gap = '0;
						next_s.bits = '0;
						if (!background_debug_active) begin
							next_s.bits = '0; // see R1
						end else if (s.shreg[7:0] >= dfch_pkg::OP_READ_NEXT
								&& s.shreg[7:0] <= dfch_pkg::OP_FETCH_STACK_POINTER) begin
							next_s.st = dfch_pkg::ST_EXEC;
						end else if (s.shreg[7:0] >= dfch_pkg::OP_WRITE_NEXT
								&& s.shreg[7:0] <= dfch_pkg::OP_LOAD_STACK_POINTER) begin
							next_s.st = dfch_pkg::ST_DATA; // see R12
						end else if (s.shreg[7:0] == dfch_pkg::OP_RESUME
								|| s.shreg[7:0] == dfch_pkg::OP_DEPRECATED_TAG_RESUME) begin
							next_s.resume = 1'b1; // see R10
							next_s.st = dfch_pkg::ST_LEAVE;
						end else if (s.shreg[7:0] == dfch_pkg::OP_RESUME_UNTIL
								|| s.shreg[7:0] == dfch_pkg::OP_SINGLE_STEP) begin
							next_s.resume = (s.shreg[7:0] == dfch_pkg::OP_RESUME_UNTIL); // see R8
							next_s.step = (s.shreg[7:0] == dfch_pkg::OP_SINGLE_STEP); // see R9
							next_s.ack_ok = 1'b1;
							next_s.left = 1'b0;
							next_s.st = dfch_pkg::ST_RETURN;
						end
						// anything else falls through and stays in opcode wait, see R25
					end
				end
				// a partly transferred opcode or word is abandoned after 512 quiet clocks
				if (!s.inbit && s.bits != '0 && s.tick == dfch_pkg::TIMEOUT_TICKS) begin
					next_s.st = dfch_pkg::ST_OPCODE; // see R23
					next_s.bits = '0;
				end
				if (s.st == dfch_pkg::ST_SEND && next_s.st == dfch_pkg::ST_SEND && next_s.inbit) begin
					if (!s.shreg[15]) begin
						next_s.pin_oe = next_s.tick <= dfch_pkg::TX0_LOW_TICKS;
						next_s.pin_out = next_s.tick == dfch_pkg::TX0_LOW_TICKS;
					end else begin
						next_s.pin_oe = next_s.tick == dfch_pkg::TX1_SPEEDUP_TICK;
						next_s.pin_out = 1'b1;
					end
				end
			end
			dfch_pkg::ST_EXEC: begin
				if (s.op == dfch_pkg::OP_READ_NEXT || s.op == dfch_pkg::OP_WRITE_NEXT) begin
					next_s.reg_wr = 1'b1; // see R3 R5
					next_s.reg_sel = dfch_pkg::REG_X;
					next_s.reg_wdata = nx;
					next_s.mem_addr = {global_page, nx[15:1], 1'b0}; // see R16
					next_s.mem_we = (s.op == dfch_pkg::OP_WRITE_NEXT);
					next_s.mem_wdata = s.shreg;
					next_s.dbgacc = dfch_in_dbg(next_s.mem_addr);
					if (next_s.dbgacc) begin
						// debug space reaches local resources; table above registers is read only
						next_s.dwait = 1'b1; // see R14
						next_s.dm_re = !next_s.mem_we;
						next_s.dm_we = next_s.mem_we && next_s.mem_addr[7:0] < dfch_pkg::DBG_REGS_END;
					end else begin
						next_s.mem_req = 1'b1;
					end
					next_s.st = dfch_pkg::ST_MEM;
				end else if (s.op[7:4] == dfch_pkg::OP_WRITE_NEXT[7:4]) begin
					next_s.reg_wr = 1'b1; // see R6
					next_s.reg_sel = dfch_reg_of(s.op);
					next_s.reg_wdata = s.shreg;
					fin = 1'b1;
				end else begin
					case (dfch_reg_of(s.op)) // see R4
						dfch_pkg::REG_PC: next_s.shreg = pc_in;
						dfch_pkg::REG_D:  next_s.shreg = d_in;
						dfch_pkg::REG_X:  next_s.shreg = x_in;
						dfch_pkg::REG_Y:  next_s.shreg = y_in;
						default:          next_s.shreg = sp_in;
					endcase
					fin = 1'b1;
					fin_to = dfch_pkg::ST_SEND;
				end
			end
			dfch_pkg::ST_MEM: begin
				fin_to = s.mem_we ? dfch_pkg::ST_OPCODE : dfch_pkg::ST_SEND;
				if (s.dbgacc) begin
					next_s.dwait = 1'b0;
					next_s.dm_re = 1'b0;
					next_s.dm_we = 1'b0;
					if (!s.dwait) begin
						if (!s.mem_we) begin
							next_s.shreg = dm_rdata;
						end
						next_s.dbgacc = 1'b0;
						fin = 1'b1;
					end
				end else if (mem_ack) begin
					next_s.mem_req = 1'b0;
					if (!s.mem_we) begin
						next_s.shreg = mem_rdata;
					end
					fin = 1'b1; // see R11
				end
			end
			dfch_pkg::ST_LEAVE: begin
				if (!background_debug_active) begin
					fin = 1'b1; // see R7
				end
			end
			dfch_pkg::ST_RETURN: begin
				if (!background_debug_active) begin
					next_s.left = 1'b1;
				end
				if (cpu_wait_stop) begin
					next_s.ack_ok = 1'b0; // see R15
				end
				if (s.left && background_debug_active) begin
					if (s.ack_ok && !cpu_wait_stop) begin
						fin = 1'b1; // see R8 R9
					end else begin
						next_s.st = dfch_pkg::ST_OPCODE;
					end
				end
			end
			dfch_pkg::ST_ACK_WAIT: begin
				if (s.gap == dfch_pkg::ACK_MIN_GAP) begin
					next_s.st = dfch_pkg::ST_ACK_LOW; // see R24
					next_s.tick = '0;
					next_s.pin_oe = 1'b1;
				end
			end
			dfch_pkg::ST_ACK_LOW: begin
				next_s.pin_oe = 1'b1;
				next_s.tick = 9'(s.tick + 9'h001);
				if (9'(s.tick + 9'h001) == dfch_pkg::ACK_LOW_TICKS) begin
					next_s.pin_out = 1'b1; // see R24
					next_s.st = dfch_pkg::ST_ACK_HIGH;
				end
			end
			default: begin
				next_s.st = s.after;
				next_s.tick = '0;
				next_s.inbit = 1'b0;
				next_s.bits = '0;
			end
		endcase
		if (fin) begin
			next_s.bits = '0;
			next_s.inbit = 1'b0;
			next_s.tick = '0;
			next_s.after = fin_to;
			// a stopped system or disabled handshake skips the pulse
			next_s.st = (ack_enable && !sys_stop) ? dfch_pkg::ST_ACK_WAIT : fin_to; // see R11 R15
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s <= dfch_pkg::RESET_REGS;
		end else begin
			s <= next_s;
		end
	end

	dfch_dbg_mem u_dbg_mem (
		.clk   (clk),
		.re    (s.dm_re),
		.we    (s.dm_we),
		.addr  (s.mem_addr[7:1]),
		.wdata (s.mem_wdata),
		.rdata (dm_rdata)
	);
	assign debug_serial_pin_out = s.pin_out;
	assign debug_serial_pin_oe  = s.pin_oe;
	assign reg_wr               = s.reg_wr;
	assign reg_sel              = s.reg_sel;
	assign reg_wdata            = s.reg_wdata;
	assign mem_req              = s.mem_req;
	assign mem_we               = s.mem_we;
	assign mem_addr             = s.mem_addr;
	assign mem_wdata            = s.mem_wdata;
	assign resume               = s.resume;
	assign step                 = s.step;
	assign debug_map_visible    = s.dbg_map;

	default clocking dfch_cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	chk_cmd_needs_bgnd: assert property ( // see R1
			$rose(resume) || $rose(step) |-> $past(background_debug_active))
		else $error("resume or step issued outside background debug");
	chk_map_follows: assert property ($rose(background_debug_active) |=> debug_map_visible) // see R2
		else $error("debug space not visible after entering background debug");
	chk_x_plus_two: assert property ($rose(s.st == dfch_pkg::ST_MEM) // see R3
			|-> reg_wr && reg_sel == dfch_pkg::REG_X && reg_wdata == 16'($past(x_in) + 16'h0002))
		else $error("next access did not advance X by two");
	chk_addr_new_x: assert property ($rose(s.st == dfch_pkg::ST_MEM) // see R5
			|-> mem_addr[15:1] == reg_wdata[15:1])
		else $error("next access address is not the new X");
	chk_load_select: assert property (reg_wr |-> reg_sel <= dfch_pkg::REG_SP) // see R6
		else $error("register load select out of range");
	chk_aligned_access: assert property (mem_req |-> !mem_addr[0]) // see R16
		else $error("misaligned memory access issued");
	chk_dbg_space_local: assert property (mem_req |-> !dfch_in_dbg(mem_addr)) // see R14
		else $error("debug space access leaked to user memory");
	chk_fw_no_write: assert property (s.dm_we |-> s.mem_addr[7:0] < dfch_pkg::DBG_REGS_END) // see R14
		else $error("write reached debug firmware table");
	chk_ack_gap: assert property ($rose(s.st == dfch_pkg::ST_ACK_LOW) // see R24
			|-> $past(s.gap) == dfch_pkg::ACK_MIN_GAP)
		else $error("acknowledge started too soon after command end");
	chk_ack_shape: assert property ($rose(s.st == dfch_pkg::ST_ACK_LOW) // see R24
			|-> (debug_serial_pin_oe && !debug_serial_pin_out) ##15
			(debug_serial_pin_oe && !debug_serial_pin_out) ##1
			(debug_serial_pin_oe && debug_serial_pin_out))
		else $error("acknowledge pulse is not 16 low clocks plus speed-up");
	chk_ack_allowed: assert property ($rose(s.st == dfch_pkg::ST_ACK_WAIT) // see R15
			|-> $past(ack_enable && !sys_stop))
		else $error("acknowledge scheduled while disabled or stopped");
	chk_link_timeout: assert property (s.st inside {dfch_pkg::ST_OPCODE, dfch_pkg::ST_DATA, // see R23
			dfch_pkg::ST_SEND} && !s.inbit && s.bits != '0 && s.tick == dfch_pkg::TIMEOUT_TICKS
			|=> s.st == dfch_pkg::ST_OPCODE && s.bits == '0)
		else $error("serial link did not time out");

	cov_resume_ack: cover property (s.st == dfch_pkg::ST_LEAVE ##1 s.st == dfch_pkg::ST_ACK_WAIT);
	cov_step_return: cover property (s.st == dfch_pkg::ST_RETURN ##1 s.st == dfch_pkg::ST_ACK_WAIT);
	cov_read_sent: cover property (s.st == dfch_pkg::ST_SEND ##1 s.st == dfch_pkg::ST_OPCODE);
	cov_next_write: cover property (mem_req && mem_we && mem_ack);
endmodule : dfch_top
`default_nettype wire

// [dv/dfch_host_model.sv]
// host pod model that drives the single-wire debug link
`default_nettype none
module dfch_host_model (
	input  wire logic clk,
	input  wire logic line,
	output var  logic host_low
);
	timeunit 1ns;
	timeprecision 1ps;

	initial host_low = 1'b0;

	// 19 clocks a bit leaves margin past the device's tick 15
	task automatic send_bit(input logic b);
		@(negedge clk);
		host_low = 1'b1;
		repeat (b ? 4 : 12) @(negedge clk);
		host_low = 1'b0;
		repeat (b ? 14 : 6) @(negedge clk);
	endtask : send_bit

	task automatic recv_bit(output logic b);
		@(negedge clk);
		host_low = 1'b1;
		repeat (2) @(negedge clk);
		// released before the device speed-up at tick 7
		host_low = 1'b0;
		repeat (8) @(negedge clk);
		b = line;
		repeat (8) @(negedge clk);
	endtask : recv_bit

	task automatic send_op(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) send_bit(v[i]);
	endtask : send_op

	task automatic send_word(input logic [15:0] v);
		for (int i = 15; i >= 0; i--) send_bit(v[i]);
	endtask : send_word

	task automatic recv_word(output logic [15:0] v);
		logic b;
		for (int i = 15; i >= 0; i--) begin
			recv_bit(b);
			v[i] = b;
		end
	endtask : recv_word
endmodule : dfch_host_model
`default_nettype wire

// [dv/dfch_top_tb.sv]
// self-checking bench of the firmware debug command handler
`default_nettype none
module dfch_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] OPS [5] = '{dfch_pkg::OP_RESUME, dfch_pkg::OP_DEPRECATED_TAG_RESUME,
		dfch_pkg::OP_RESUME_UNTIL, dfch_pkg::OP_SINGLE_STEP, dfch_pkg::OP_RESUME_UNTIL};
	logic        clk, nrst, act, ack_en, stp, cws, low, line, wr;
	logic        mem_ack = 1'b0;
	logic        pin_out, pin_oe, rwr, mreq, mwe, res, stepo, vis, c_we;
	logic [15:0] cpu [5];
	logic [15:0] w, v, dv, rwd, mwd, c_wd, c_mwd;
	logic [15:0] mrd = 16'h0000;
	logic [6:0]  page;
	logic [2:0]  rsel, c_sel;
	logic [22:0] madr, eadr, c_adr;
	int          errors, n_compared, n_ack, n_wr, n_mem, n_res, n_step, run, lat, a0, r0, m0;

	// pull-up wins when nobody drives
	assign line = pin_oe ? pin_out : ~low;

	dfch_top u_dut (.clk(clk), .nrst(nrst), .debug_serial_pin_in(line),
		.debug_serial_pin_out(pin_out), .debug_serial_pin_oe(pin_oe),
		.background_debug_active(act), .ack_enable(ack_en), .sys_stop(stp),
		.cpu_wait_stop(cws), .pc_in(cpu[0]), .d_in(cpu[1]), .x_in(cpu[2]), .y_in(cpu[3]),
		.sp_in(cpu[4]), .global_page(page), .reg_wr(rwr), .reg_sel(rsel), .reg_wdata(rwd),
		.mem_req(mreq), .mem_we(mwe), .mem_addr(madr), .mem_wdata(mwd), .mem_ack(mem_ack),
		.mem_rdata(mrd), .resume(res), .step(stepo), .debug_map_visible(vis));

	dfch_host_model u_host (.clk(clk), .line(line), .host_low(low));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [15:0] mexp(input logic [22:0] a);
		return a[15:0] ^ 16'h5A3C;
	endfunction : mexp

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out;
		$display("compared=%0d errors=%0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : close_out

	task automatic wait_ack(input int prev);
		for (int i = 0; i < 3000 && n_ack == prev; i++) @(negedge clk);
		chk(n_ack, prev + 1);
	endtask : wait_ack

	always @(posedge clk) begin
		if (rwr === 1'b1) begin
			n_wr++;
			c_sel = rsel;
			c_wd = rwd;
		end
		if (mreq === 1'b1 && mem_ack === 1'b1) begin
			n_mem++;
			c_adr = madr;
			c_we = mwe;
			c_mwd = mwd;
		end
		if (res === 1'b1) n_res++;
		if (stepo === 1'b1) n_step++;
		if (pin_oe === 1'b1 && pin_out === 1'b0) run++;
		else if (run != 0) begin
			if (run == 16) n_ack++;
			else chk(run, 13);
			chk({pin_oe, pin_out}, 2'b11);
			run = 0;
		end
	end

	// memory with random latency; data is junk outside the ack cycle
	always @(negedge clk) begin
		if (mreq === 1'b1 && !mem_ack) begin
			if (lat == 0) begin
				mem_ack <= 1'b1;
				mrd <= mexp(madr);
				lat <= $urandom_range(4);
			end else lat <= lat - 1;
		end else begin
			mem_ack <= 1'b0;
			mrd <= ~mrd;
		end
	end

	initial begin
		{nrst, act, ack_en, stp, cws} = 5'h00;
		page = 7'h00;
		foreach (cpu[i]) cpu[i] = 16'h0000;
		void'($urandom(26));
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		act = 1'b1;
		repeat (3) @(negedge clk);
		foreach (cpu[i]) cpu[i] = $urandom;
		page = $urandom_range(126);
		chk(vis, 1);
		// a broken frame must be dropped after the idle time-out
		for (int i = 0; i < 3; i++) u_host.send_bit(1'b0);
		repeat (600) @(negedge clk);
		for (int i = 0; i < 5; i++) begin
			u_host.send_op(dfch_pkg::OP_FETCH_PROGRAM_COUNTER + 8'(i));
			repeat (48) @(negedge clk);
			u_host.recv_word(w);
			chk(w, cpu[i]);
		end
		ack_en = 1'b1;
		for (int i = 0; i < 5; i++) begin
			v = $urandom;
			a0 = n_ack;
			r0 = n_wr;
			u_host.send_op(dfch_pkg::OP_LOAD_PROGRAM_COUNTER + 8'(i));
			u_host.send_word(v);
			repeat (20) @(negedge clk);
			chk(n_ack - a0 + run, 0);
			wait_ack(a0);
			chk(n_wr, r0 + 1);
			chk({c_sel, c_wd}, {3'(i), v});
		end
		// next-access: read and write outside, then write and read back in debug space
		for (int k = 0; k < 4; k++) begin
			wr = k[0] ^ k[1];
			if (k == 2) page = 7'h7F;
			cpu[2] = k[1] ? 16'hFEFE : ($urandom | 16'h0001);
			v = $urandom;
			eadr = {page, cpu[2] + 16'h0002} & 23'h7FFFFE;
			a0 = n_ack;
			m0 = n_mem;
			u_host.send_op(wr ? dfch_pkg::OP_WRITE_NEXT : dfch_pkg::OP_READ_NEXT);
			if (wr) u_host.send_word(v);
			wait_ack(a0);
			chk({c_sel, c_wd}, {dfch_pkg::REG_X, cpu[2] + 16'h0002});
			if (!wr) u_host.recv_word(w);
			if (k[1]) begin
				chk(n_mem, m0);
				if (wr) dv = v;
				else chk(w, dv);
			end else begin
				chk(n_mem, m0 + 1);
				chk({c_we, c_adr}, {wr, eadr});
				chk(wr ? c_mwd : w, wr ? v : mexp(eadr));
			end
		end
		a0 = n_ack;
		r0 = n_wr;
		m0 = n_res + n_step;
		u_host.send_op(8'h55);
		repeat (80) @(negedge clk);
		chk(n_wr, r0);
		act = 1'b0;
		repeat (2) @(negedge clk);
		chk(vis, 0);
		u_host.send_op(dfch_pkg::OP_RESUME);
		repeat (80) @(negedge clk);
		chk(n_res + n_step, m0);
		act = 1'b1;
		stp = 1'b1;
		u_host.send_op(dfch_pkg::OP_LOAD_PROGRAM_COUNTER + 8'h01);
		u_host.send_word(v);
		repeat (150) @(negedge clk);
		chk(n_wr, r0 + 1);
		chk(n_ack, a0);
		stp = 1'b0;
		// resume family; the last pass has the cpu stop before returning
		for (int k = 0; k < 5; k++) begin
			a0 = n_ack;
			m0 = n_res + n_step;
			r0 = n_step;
			u_host.send_op(OPS[k]);
			for (int i = 0; i < 300 && n_res + n_step == m0; i++) @(negedge clk);
			chk(n_res + n_step, m0 + 1);
			chk(n_step - r0, (k == 3) ? 1 : 0);
			repeat (40) @(negedge clk);
			chk(n_ack, a0);
			act = 1'b0;
			if (k < 2) begin
				wait_ack(a0);
				act = 1'b1;
			end else begin
				repeat (40) @(negedge clk);
				chk(n_ack, a0);
				cws = (k == 4);
				@(negedge clk);
				cws = 1'b0;
				act = 1'b1;
				if (k < 4) wait_ack(a0);
				else begin
					repeat (200) @(negedge clk);
					chk(n_ack, a0);
				end
			end
			repeat (76) @(negedge clk);
		end
		close_out();
	end

	initial begin
		repeat (40000) @(negedge clk);
		errors++;
		close_out();
	end
endmodule : dfch_top_tb
`default_nettype wire
